// ### common/phase_if.sv
`timescale 1ns/1ps

interface phase_if;
	logic start;
	rsx_pkg::phase_e phase;

	modport seq (input start, output phase);
	modport core (output start, input phase);
endinterface

// ### common/rsx_map.svh
`ifndef RSX_MAP_SVH
`define RSX_MAP_SVH

// Register byte offsets
`define RSX_OFF_INSTR 8'h00
`define RSX_OFF_WREG 8'h04
`define RSX_OFF_BANKSEL 8'h08
`define RSX_OFF_STATUS 8'h0C
`define RSX_OFF_WAKE 8'h10
`define RSX_OFF_WDOG 8'h14
`define RSX_OFF_FADDR 8'h18
`define RSX_OFF_FDATA 8'h1C

// Status register bit positions
`define RSX_ST_Z 0
`define RSX_ST_N 1
`define RSX_ST_PWRDN 2
`define RSX_ST_TMOUT 3
`define RSX_ST_SLEEP 4
`define RSX_ST_BUSY 5
`define RSX_ST_BADOP 6

// Wake register bit: software wake request
`define RSX_WAKE_SW 0

// Reset values
`define RSX_TMOUT_RST 1'b1
`define RSX_PWRDN_RST 1'b1
`define RSX_WAIT_RST 1'b1

// Opcode patterns
`define RSX_ROT_MATCH 6'h10
`define RSX_SET_MATCH 7'h34
`define RSX_SLEEP_WORD 16'h0003
`define RSX_ALL_ONES 8'hFF

// Access bank split point and watchdog postscaler terminal count
`define RSX_ACCESS_SPLIT 8'h80
`define RSX_WDOG_POST_MAX 16'h007F

`endif

// ### common/rsx_pkg.sv
package rsx_pkg;

	typedef enum {PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_e;

	typedef enum {OP_NONE, OP_ROT, OP_SET, OP_SLEEP} op_e;

endpackage

// ### core/q_sequencer.sv
`timescale 1ns/1ps

module q_sequencer (
	input wire logic clk_in,
	input wire logic nrst_in,
	phase_if.seq ph
);

	rsx_pkg::phase_e phase_reg;
	rsx_pkg::phase_e phase_next;

	// One instruction cycle: four phases, then back to idle
	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			rsx_pkg::PH_IDLE: begin
				if (ph.start) begin
					phase_next = rsx_pkg::PH_DECODE;
				end
			end
			rsx_pkg::PH_DECODE: phase_next = rsx_pkg::PH_READ;
			rsx_pkg::PH_READ: phase_next = rsx_pkg::PH_PROCESS;
			rsx_pkg::PH_PROCESS: phase_next = rsx_pkg::PH_WRITE;
			rsx_pkg::PH_WRITE: phase_next = rsx_pkg::PH_IDLE;
			default: phase_next = rsx_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			phase_reg <= rsx_pkg::PH_IDLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	assign ph.phase = phase_reg;

endmodule

// ### core/rotate_set_sleep_exec.sv
// Overview of operation
// - Rotate opcode rotates file register right, bit 0 to bit 7; updates N, Z only.
// - Rotate with destination bit zero writes working register, file register untouched.
// - Rotate with destination bit one writes result back into the file register.
// - Bank bit zero addresses the access bank, ignoring the bank-select register.
// - Bank bit one takes the bank from the bank-select register.
// - Set-file opcode loads all ones into the file register, flags unchanged.
// - Sleep opcode clears the power-down flag.
// - Sleep opcode sets the time-out flag.
// - Sleep opcode clears the watchdog counter and its postscaler.
// - After sleep, instruction cycles stop until a wake-up.
// - Wake-up caused by the watchdog clears the time-out flag.
`timescale 1ns/1ps
`include "rsx_map.svh"

module rotate_set_sleep_exec #(
	parameter int BANK_W = 4,
	parameter int POST_W = 16,
	parameter logic [POST_W-1:0] POST_MAX = `RSX_WDOG_POST_MAX
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic sleeping_out,
	output logic timeout_flag_out,
	output logic powerdown_flag_out
);

	localparam int AW = BANK_W + 8;
	localparam int DEPTH = 1 << AW;

	// File register space
	logic [7:0] file_mem [DEPTH];

	phase_if ph ();

	q_sequencer u_seq (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.ph(ph.seq)
	);

	// Bus state
	logic wait_reg;
	logic wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// Execution state
	logic [15:0] instr_reg;
	logic [15:0] instr_next;
	rsx_pkg::op_e op_reg;
	rsx_pkg::op_e op_next;
	logic [AW-1:0] faddr_reg;
	logic [AW-1:0] faddr_next;
	logic dest_f_reg;
	logic dest_f_next;
	logic [7:0] operand_reg;
	logic [7:0] operand_next;
	logic [7:0] result_reg;
	logic [7:0] result_next;
	logic [7:0] wreg_reg;
	logic [7:0] wreg_next;
	logic [BANK_W-1:0] bank_select_register_reg;
	logic [BANK_W-1:0] bank_select_register_next;
	logic n_reg;
	logic n_next;
	logic z_reg;
	logic z_next;
	logic timeout_flag_reg;
	logic timeout_flag_next;
	logic powerdown_flag_reg;
	logic powerdown_flag_next;
	logic sleep_reg;
	logic sleep_next;
	logic badop_reg;
	logic badop_next;
	logic [AW-1:0] host_addr_reg;
	logic [AW-1:0] host_addr_next;

	// Watchdog state
	logic [7:0] watchdog_counter_reg;
	logic [7:0] watchdog_counter_next;
	logic [POST_W-1:0] post_reg;
	logic [POST_W-1:0] post_next;

	// Shared decode terms
	logic busy;
	logic acc;
	logic wr_acc;
	logic [31:0] wmerged;
	logic hit_instr;
	logic hit_wreg;
	logic hit_banksel;
	logic hit_wake;
	logic hit_faddr;
	logic hit_fdata;
	logic sleep_go;
	logic wdt_wake;
	logic sw_wake;
	logic mem_we;
	logic [AW-1:0] mem_wa;
	logic [7:0] mem_wd;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign busy = (ph.phase != rsx_pkg::PH_IDLE);
	assign acc = (avs_read_in || avs_write_in) && !wait_reg;
	assign wr_acc = avs_write_in && !wait_reg;
	assign wmerged = be_merge(32'h0000_0000, avs_writedata_in, avs_byteenable_in);
	assign hit_instr = (avs_address_in == `RSX_OFF_INSTR);
	assign hit_wreg = (avs_address_in == `RSX_OFF_WREG);
	assign hit_banksel = (avs_address_in == `RSX_OFF_BANKSEL);
	assign hit_wake = (avs_address_in == `RSX_OFF_WAKE);
	assign hit_faddr = (avs_address_in == `RSX_OFF_FADDR);
	assign hit_fdata = (avs_address_in == `RSX_OFF_FDATA);

	// A new instruction is taken only while awake and idle
	assign ph.start = wr_acc && hit_instr && !sleep_reg && !busy;
	assign sleep_go = (ph.phase == rsx_pkg::PH_WRITE) && (op_reg == rsx_pkg::OP_SLEEP);
	assign wdt_wake = sleep_reg && (watchdog_counter_reg == 8'hFF) && (post_reg == POST_MAX);
	assign sw_wake = sleep_reg && wr_acc && hit_wake && wmerged[`RSX_WAKE_SW];

	// Bus: one wait cycle, then a single-cycle answer; writes stall while executing
	always_comb begin
		wait_next = `RSX_WAIT_RST;
		rdata_next = rdata_reg;
		if ((avs_read_in || avs_write_in) && wait_reg && !(avs_write_in && busy)) begin
			wait_next = 1'b0;
			rdata_next = 32'h0000_0000;
			case (avs_address_in)
				`RSX_OFF_INSTR: rdata_next[15:0] = instr_reg;
				`RSX_OFF_WREG: rdata_next[7:0] = wreg_reg;
				`RSX_OFF_BANKSEL: rdata_next[BANK_W-1:0] = bank_select_register_reg;
				`RSX_OFF_STATUS: begin
					rdata_next[`RSX_ST_Z] = z_reg;
					rdata_next[`RSX_ST_N] = n_reg;
					rdata_next[`RSX_ST_PWRDN] = powerdown_flag_reg;
					rdata_next[`RSX_ST_TMOUT] = timeout_flag_reg;
					rdata_next[`RSX_ST_SLEEP] = sleep_reg;
					rdata_next[`RSX_ST_BUSY] = busy;
					rdata_next[`RSX_ST_BADOP] = badop_reg;
				end
				`RSX_OFF_WDOG: rdata_next[7:0] = watchdog_counter_reg;
				`RSX_OFF_FADDR: rdata_next[AW-1:0] = host_addr_reg;
				`RSX_OFF_FDATA: rdata_next[7:0] = file_mem[host_addr_reg];
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wait_reg <= `RSX_WAIT_RST;
			rdata_reg <= 32'h0000_0000;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// Execution and register file
	always_comb begin
		instr_next = instr_reg;
		op_next = op_reg;
		faddr_next = faddr_reg;
		dest_f_next = dest_f_reg;
		operand_next = operand_reg;
		result_next = result_reg;
		wreg_next = wreg_reg;
		bank_select_register_next = bank_select_register_reg;
		n_next = n_reg;
		z_next = z_reg;
		timeout_flag_next = timeout_flag_reg;
		powerdown_flag_next = powerdown_flag_reg;
		sleep_next = sleep_reg;
		badop_next = badop_reg;
		host_addr_next = host_addr_reg;
		mem_we = 1'b0;
		mem_wa = host_addr_reg;
		mem_wd = wmerged[7:0];

		if (wr_acc && !busy) begin
			if (ph.start) begin
				instr_next = wmerged[15:0];
			end
			if (hit_wreg) begin
				wreg_next = wmerged[7:0];
			end
			if (hit_banksel) begin
				bank_select_register_next = wmerged[BANK_W-1:0];
			end
			if (hit_faddr) begin
				host_addr_next = wmerged[AW-1:0];
			end
			if (hit_fdata) begin
				mem_we = 1'b1;
			end
		end

		case (ph.phase)
			rsx_pkg::PH_DECODE: begin
				op_next = rsx_pkg::OP_NONE;
				badop_next = 1'b0;
				dest_f_next = 1'b1;
				if (instr_reg[15:10] == `RSX_ROT_MATCH) begin
					op_next = rsx_pkg::OP_ROT;
					dest_f_next = instr_reg[9];
				end else if (instr_reg[15:9] == `RSX_SET_MATCH) begin
					op_next = rsx_pkg::OP_SET;
				end else if (instr_reg == `RSX_SLEEP_WORD) begin
					op_next = rsx_pkg::OP_SLEEP;
				end else begin
					badop_next = 1'b1;
				end
				if (instr_reg[8]) begin
					faddr_next = {bank_select_register_reg, instr_reg[7:0]};
				end else if (instr_reg[7:0] < `RSX_ACCESS_SPLIT) begin
					faddr_next = {{BANK_W{1'b0}}, instr_reg[7:0]};
				end else begin
					faddr_next = {{BANK_W{1'b1}}, instr_reg[7:0]};
				end
			end
			rsx_pkg::PH_READ: begin
				operand_next = file_mem[faddr_reg];
			end
			rsx_pkg::PH_PROCESS: begin
				if (op_reg == rsx_pkg::OP_ROT) begin
					result_next = {operand_reg[0], operand_reg[7:1]};
				end else begin
					result_next = `RSX_ALL_ONES;
				end
			end
			rsx_pkg::PH_WRITE: begin
				case (op_reg)
					rsx_pkg::OP_ROT: begin
						n_next = result_reg[7];
						z_next = (result_reg == 8'h00);
						if (dest_f_reg) begin
							mem_we = 1'b1;
							mem_wa = faddr_reg;
							mem_wd = result_reg;
						end else begin
							wreg_next = result_reg;
						end
					end
					rsx_pkg::OP_SET: begin
						mem_we = 1'b1;
						mem_wa = faddr_reg;
						mem_wd = result_reg;
					end
					rsx_pkg::OP_SLEEP: begin
						powerdown_flag_next = 1'b0;
						timeout_flag_next = 1'b1;
						sleep_next = 1'b1;
					end
					default: begin
						mem_we = 1'b0;
					end
				endcase
			end
			default: begin
				mem_we = mem_we;
			end
		endcase

		if (wdt_wake) begin
			sleep_next = 1'b0;
			timeout_flag_next = 1'b0;
		end else if (sw_wake) begin
			sleep_next = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			instr_reg <= 16'h0000;
			op_reg <= rsx_pkg::OP_NONE;
			faddr_reg <= '0;
			dest_f_reg <= 1'b1;
			operand_reg <= 8'h00;
			result_reg <= 8'h00;
			wreg_reg <= 8'h00;
			bank_select_register_reg <= '0;
			n_reg <= 1'b0;
			z_reg <= 1'b0;
			timeout_flag_reg <= `RSX_TMOUT_RST;
			powerdown_flag_reg <= `RSX_PWRDN_RST;
			sleep_reg <= 1'b0;
			badop_reg <= 1'b0;
			host_addr_reg <= '0;
		end else begin
			instr_reg <= instr_next;
			op_reg <= op_next;
			faddr_reg <= faddr_next;
			dest_f_reg <= dest_f_next;
			operand_reg <= operand_next;
			result_reg <= result_next;
			wreg_reg <= wreg_next;
			bank_select_register_reg <= bank_select_register_next;
			n_reg <= n_next;
			z_reg <= z_next;
			timeout_flag_reg <= timeout_flag_next;
			powerdown_flag_reg <= powerdown_flag_next;
			sleep_reg <= sleep_next;
			badop_reg <= badop_next;
			host_addr_reg <= host_addr_next;
		end
	end

	// File memory has no reset; contents are undefined until written
	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			file_mem[mem_wa] <= mem_wd;
		end
	end

	// Watchdog runs on its own tick even while asleep; overflow only matters asleep
	always_comb begin
		watchdog_counter_next = watchdog_counter_reg;
		post_next = post_reg;
		if (sleep_go) begin
			watchdog_counter_next = 8'h00;
			post_next = '0;
		end else if (post_reg == POST_MAX) begin
			post_next = '0;
			watchdog_counter_next = watchdog_counter_reg + 8'h01;
		end else begin
			post_next = post_reg + {{(POST_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			watchdog_counter_reg <= 8'h00;
			post_reg <= '0;
		end else begin
			watchdog_counter_reg <= watchdog_counter_next;
			post_reg <= post_next;
		end
	end

	assign avs_readdata_out = rdata_reg;
	assign avs_waitrequest_out = wait_reg;
	assign sleeping_out = sleep_reg;
	assign timeout_flag_out = timeout_flag_reg;
	assign powerdown_flag_out = powerdown_flag_reg;

endmodule

// ### dv/rsx_monitor.sv
`timescale 1ns/1ps

module rsx_monitor (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic sleeping_out,
	input wire logic timeout_flag_out,
	input wire logic powerdown_flag_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_wait_one_low: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	a_read_answer: assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("read not answered in one cycle");
	a_write_bounded: assert property (avs_write_in && avs_waitrequest_out
		|-> ##[1:6] !avs_waitrequest_out) else $error("write not answered in time");
	a_idle_no_ack: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
		else $error("answer without request");
	a_sleep_clears_pd: assert property ($rose(sleeping_out) |-> !powerdown_flag_out)
		else $error("power-down flag set at sleep entry");
	a_sleep_sets_to: assert property ($rose(sleeping_out) |-> timeout_flag_out)
		else $error("time-out flag clear at sleep entry");
	a_pd_fall_cause: assert property ($fell(powerdown_flag_out) |-> $rose(sleeping_out))
		else $error("power-down flag cleared outside sleep entry");
	a_to_rise_cause: assert property ($rose(timeout_flag_out) |-> $rose(sleeping_out))
		else $error("time-out flag set outside sleep entry");
	a_to_fall_wake: assert property ($fell(timeout_flag_out) |-> $fell(sleeping_out))
		else $error("time-out flag cleared without wake");
	a_sleep_pd_held: assert property (sleeping_out |-> !powerdown_flag_out)
		else $error("power-down flag high while asleep");
	a_sleep_timing: assert property ($rose(sleeping_out)
		|-> $past(avs_write_in && !avs_waitrequest_out, 5))
		else $error("sleep entry not four phases after instruction");
	a_wake_cause: assert property ($fell(sleeping_out) && $past(nrst_in)
		|-> $past(avs_write_in) || $past(avs_write_in, 2) || !timeout_flag_out)
		else $error("left sleep without wake request");
endmodule

bind rotate_set_sleep_exec rsx_monitor u_mon (.clk_in, .nrst_in, .avs_address_in, .avs_read_in,
	.avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
	.avs_waitrequest_out, .sleeping_out, .timeout_flag_out, .powerdown_flag_out);

// ### dv/tb_top.sv
`timescale 1ns/1ps
`include "rsx_map.svh"

module tb_top;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] avs_address_in = 8'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h00000000;
	logic [3:0] avs_byteenable_in = 4'hF;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic sleeping_out;
	logic timeout_flag_out;
	logic powerdown_flag_out;
	logic [31:0] rd;
	int fail_count = 0;
	int samples_checked = 0;

	rotate_set_sleep_exec #(.POST_MAX(16'h0002)) u_dut (.clk_in, .nrst_in, .avs_address_in,
		.avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .sleeping_out, .timeout_flag_out, .powerdown_flag_out);

	always #20 clk_in = ~clk_in;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0 && n < 100) begin
			@(posedge clk_in);
			n++;
		end
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		if (n >= 100) chk(32'h00000001, 32'h00000000);
	endtask

	task automatic poke(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, `RSX_OFF_FADDR, {20'h00000, a});
		bus(1'b1, `RSX_OFF_FDATA, {24'h000000, d});
	endtask

	task automatic fget(input logic [11:0] a);
		bus(1'b1, `RSX_OFF_FADDR, {20'h00000, a});
		bus(1'b0, `RSX_OFF_FDATA, 32'h00000000);
	endtask

	// Four phases of one instruction cycle follow the accepted write
	task automatic exec(input logic [15:0] op);
		bus(1'b1, `RSX_OFF_INSTR, {16'h0000, op});
		repeat (5) @(posedge clk_in);
	endtask

	task automatic flags(input logic [1:0] exp);
		bus(1'b0, `RSX_OFF_STATUS, 32'h00000000);
		chk(rd & 32'h00000003, {30'h00000000, exp});
	endtask

	task automatic t_rotate;
		bus(1'b1, `RSX_OFF_BANKSEL, 32'h00000005);
		poke(12'h540, 8'hD7);
		poke(12'h040, 8'h00);
		exec(16'h4340);
		fget(12'h540);
		chk(rd, 32'h000000EB);
		flags(2'b10);
		exec(16'h4140);
		bus(1'b0, `RSX_OFF_WREG, 32'h00000000);
		chk(rd, 32'h000000F5);
		fget(12'h540);
		chk(rd, 32'h000000EB);
		exec(16'h4240);
		fget(12'h040);
		chk(rd, 32'h00000000);
		flags(2'b01);
		fget(12'h540);
		chk(rd, 32'h000000EB);
		$display("test rotate done");
	endtask

	task automatic t_load_all_ones_op;
		poke(12'h540, 8'h5A);
		exec(16'h6940);
		bus(1'b0, `RSX_OFF_STATUS, 32'h00000000);
		chk(rd[5], 1'b0);
		fget(12'h540);
		chk(rd, 32'h000000FF);
		flags(2'b01);
		poke(12'h040, 8'h12);
		exec(16'h6840);
		fget(12'h040);
		chk(rd, 32'h000000FF);
		bus(1'b1, `RSX_OFF_BANKSEL, 32'h00000002);
		poke(12'h240, 8'h33);
		exec(16'h6940);
		fget(12'h240);
		chk(rd, 32'h000000FF);
		bus(1'b1, `RSX_OFF_BANKSEL, 32'h00000005);
		$display("test load_all_ones_op done");
	endtask

	task automatic t_sleep;
		exec(16'h0003);
		chk(sleeping_out, 1'b1);
		chk(powerdown_flag_out, 1'b0);
		chk(timeout_flag_out, 1'b1);
		bus(1'b0, `RSX_OFF_WDOG, 32'h00000000);
		chk(rd < 32'h00000010, 1'b1);
		poke(12'h540, 8'h3C);
		exec(16'h6940);
		fget(12'h540);
		chk(rd, 32'h0000003C);
		bus(1'b1, `RSX_OFF_WAKE, 32'h00000001);
		repeat (2) @(posedge clk_in);
		chk(sleeping_out, 1'b0);
		chk(timeout_flag_out, 1'b1);
		$display("test sleep done");
	endtask

	task automatic t_wdog_wake;
		int n;
		n = 0;
		exec(16'h0003);
		while (sleeping_out === 1'b1 && n < 2000) begin
			@(posedge clk_in);
			n++;
		end
		chk(n > 700, 1'b1);
		chk(timeout_flag_out, 1'b0);
		exec(16'h0003);
		chk(timeout_flag_out, 1'b1);
		bus(1'b1, `RSX_OFF_WAKE, 32'h00000001);
		bus(1'b0, 8'h20, 32'h00000000);
		chk(rd, 32'h00000000);
		// Unknown opcode raises the bad-opcode status bit
		exec(16'h1234);
		bus(1'b0, `RSX_OFF_STATUS, 32'h00000000);
		chk(rd[6], 1'b1);
		$display("test watchdog wake done");
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		#(40 * 6000);
		fail_count++;
		end_of_test();
	end

	initial begin
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		chk({sleeping_out, timeout_flag_out, powerdown_flag_out}, 3'b011);
		t_rotate();
		t_load_all_ones_op();
		t_sleep();
		t_wdog_wake();
		end_of_test();
	end
endmodule
